// >>> common/swfsr_pkg.sv
// Shared constants for the shadow write buffer with paired reads.
// Assumes a single core clock; users import the whole package or name its types with swfsr_pkg::.
package swfsr_pkg;
  localparam int DATA_W     = 32;
  localparam int IDX_W      = 8;
  localparam int ADDR_W     = 9;
  localparam int BLK_BIT    = 8;
  localparam int NBLK       = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW    = 3;
  localparam logic [IDX_W-1:0]  COMPANION_STEP = 8'h01;
  localparam logic [FIFO_AW:0]  IO_ROOM_LIMIT  = 4'h6;
  localparam logic [DATA_W-1:0] DATA_RESET     = 32'h0000_0000;
  typedef logic [ADDR_W-1:0] swfsr_addr_type;
  typedef logic [DATA_W-1:0] swfsr_data_type;
endpackage : swfsr_pkg

// >>> dv/swfsr_io_model.sv
// I/O side model: reads block 1 while ready, writes now and then, drains with stalls.
// Assumes the swfsr_top I/O contract.
module swfsr_io_model (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                en,
  input  wire logic                ioReady_ff,
  input  wire logic                ioRdValid,
  output logic                     ioWrite = 1'h0,
  output logic                     ioRead = 1'h0,
  output swfsr_pkg::swfsr_addr_type ioAddr = 9'h000,
  output swfsr_pkg::swfsr_data_type ioWrData = 32'h0000_0000,
  output logic                     ioRdReady = 1'h0,
  output int                       reads = 0,
  output int                       pops = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  import swfsr_pkg::*;
  logic [7:0] cnt_ff = 8'h00;
  wire logic  rdNow = en && ioReady_ff;
  wire logic  wrNow = en && !ioReady_ff && cnt_ff[0];
  always @(posedge mclk) begin
    cnt_ff <= cnt_ff + 8'h01;
    ioRead <= rdNow && !rst;
    ioWrite <= wrNow && !rst;
    ioRdReady <= cnt_ff[1];
    ioAddr <= rdNow ? {1'h1, cnt_ff} : wrNow ? {2'h3, cnt_ff[6:0]} : ~ioAddr;
    ioWrData <= wrNow ? {4{cnt_ff}} : ~ioWrData;
    reads <= rst ? 0 : reads + int'(ioRead && ioReady_ff);
    pops <= rst ? 0 : pops + int'(ioRdValid && ioRdReady);
  end
endmodule // swfsr_io_model

// >>> dv/swfsr_properties.sv
// Checker for swfsr_top port timing.
// Assumes one clock mclk and synchronous active-high rst.
module swfsr_properties (
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      coreRead,
  input wire logic                      corePaired,
  input wire swfsr_pkg::swfsr_data_type primaryElem_ff,
  input wire swfsr_pkg::swfsr_data_type secondaryElem_ff,
  input wire logic                      coreRdValid_ff,
  input wire logic                      ioRead,
  input wire logic                      ioReady_ff,
  input wire logic                      ioRdValid,
  input wire logic                      ioRdReady,
  input wire swfsr_pkg::swfsr_data_type ioRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  a_rd_valid: assert property (coreRead |=> coreRdValid_ff) else $error("no answer");
  a_no_extra: assert property (!coreRead |=> !coreRdValid_ff) else $error("extra valid");
  a_single_sec: assert property (coreRead && !corePaired |=> secondaryElem_ff == '0)
    else $error("secondary not clear");
  a_elems_hold: assert property (!coreRead |=> $stable(primaryElem_ff) && $stable(secondaryElem_ff))
    else $error("elements moved");
  a_reset_quiet: assert property ($fell(rst) |-> !coreRdValid_ff && !ioRdValid)
    else $error("busy after reset");
  a_ready_rise: assert property ($fell(rst) |-> ##[1:2] ioReady_ff) else $error("not ready");
  a_io_hold: assert property (ioRdValid && !ioRdReady |=> ioRdValid && $stable(ioRdData))
    else $error("return word lost");
  a_io_answer: assert property (ioRead && ioReady_ff |-> ##[2:8] ioRdValid)
    else $error("io read unanswered");
  cover property (coreRead && corePaired);
  cover property (ioRead && ioReady_ff);
  cover property (!ioReady_ff ##1 ioReady_ff);
endmodule // swfsr_properties

bind swfsr_top swfsr_properties u_props (.mclk, .rst, .coreRead, .corePaired, .primaryElem_ff,
  .secondaryElem_ff, .coreRdValid_ff, .ioRead, .ioReady_ff, .ioRdValid, .ioRdReady, .ioRdData);

// >>> dv/testbench.sv
// Testbench for swfsr_top: paired reads, write forwarding, I/O return path.
// Assumes swfsr_io_model stands on the I/O side.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import swfsr_pkg::*;
  logic mclk = 0, rst = 1, coreWrite = 0, coreRead = 0, corePaired = 0, coreSec = 0, en = 0;
  logic rdv, ioWrite, ioRead, ioReady, ioRdValid, ioRdReady, full = 0;
  swfsr_addr_type coreAddr = '0, ioAddr;
  swfsr_data_type coreWrData = '0, pri, sec, ioWrData, ioRdData;
  int err_total = 0, n_compared = 0, reads, pops;
  always #10 mclk = ~mclk;
  always @(posedge mclk) full <= full | (en & !ioReady);
  swfsr_top u_dut (.mclk, .rst, .coreWrite, .coreRead, .corePaired,
    .coreExplicitSecondary(coreSec), .coreAddr, .coreWrData, .primaryElem_ff(pri),
    .secondaryElem_ff(sec), .coreRdValid_ff(rdv), .ioWrite, .ioRead, .ioAddr, .ioWrData,
    .ioReady_ff(ioReady), .ioRdValid, .ioRdReady, .ioRdData);
  swfsr_io_model u_io (.mclk, .rst, .en, .ioReady_ff(ioReady), .ioRdValid, .ioWrite,
    .ioRead, .ioAddr, .ioWrData, .ioRdReady, .reads, .pops);
  function automatic swfsr_data_type dv(int a);
    return 32'hC0DE_0000 | a;
  endfunction
  task automatic cmp(string n, swfsr_data_type e, swfsr_data_type g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic op(logic w, r, p, s, int a, int d);
    @(posedge mclk);
    {coreWrite, coreRead, corePaired, coreSec} <= {w, r, p, s};
    coreAddr <= swfsr_addr_type'(a);
    coreWrData <= w ? dv(d) : ~coreWrData;
  endtask
  task automatic rd(logic p, s, int a, swfsr_data_type ep, es);
    op(0, 1, p, s, a, 0);
    op(0, 0, 0, 0, a, 0);
    #1;
    cmp("primary", ep, pri);
    cmp("secondary", es, sec);
    cmp("valid", 1, rdv);
  endtask
  task automatic t_pair;
    for (int i = 0; i < 8; i++) op(1, 0, 0, 0, i, i);
    op(1, 0, 0, 0, 255, 255);
    repeat (3) op(0, 0, 0, 0, 0, 0);
    rd(1, 0, 1, dv(1), dv(2));
    rd(1, 1, 1, dv(2), dv(1));
    rd(1, 0, 255, dv(255), dv(0));
    op(1, 0, 0, 0, 3, 33);
    op(1, 0, 0, 0, 4, 44);
    rd(1, 0, 3, dv(33), dv(44));
    rd(1, 1, 3, dv(44), dv(33));
    rd(0, 0, 3, dv(33), '0);
    $display("pair test done");
  endtask
  task automatic t_mix;
    en <= 1;
    for (int i = 288; i < 304; i++) begin
      op(1, 0, 0, 0, i, i);
      op(1, 0, 0, 0, i + 1, i + 100);
      rd(0, 0, i, dv(i), '0);
    end
    op(1, 0, 0, 0, 320, 7);
    repeat (2) op(0, 0, 0, 0, 0, 0);
    rd(0, 0, 320, dv(7), '0);
    rd(1, 0, 5, dv(5), dv(6));
    $display("mix test done");
  endtask
  task automatic t_io;
    en <= 0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 64 && ioRdValid !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    cmp("io words", reads, pops);
    cmp("io refused", 1, full);
    $display("io test done");
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 0;
    t_pair;
    t_mix;
    t_io;
    conclude;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    conclude;
  end
endmodule // testbench

// >>> hw/swfsr_top.sv
// Shadow write buffer per memory block, paired-element reads, I/O return FIFO.
// Assumes requests are synchronous to mclk and the core issues at most one
// access per cycle; the I/O side waits for ioReady_ff before a read.
//
// Summary of operation
// R1 - Any explicit pair read: companion goes higher, except 255 wraps to 0
// R2 - Explicit register gets explicit word, other companion
// R3 - Buffered pair reads use same companion handling
// R4 - Write then two non-read cycles reads back
// R5 - Blocks never disturb each other's buffer
// R6 - Transmit DMA reads every cycle until full
// R7 - Receive DMA requests arrive intermittently
// R8 - Writes enter stage one of two stages, except a core write alongside an I/O write
// R9 - Stage one advances on write or idle
// R10 - One buffer per block shared by both
// R11 - Memory double pumped: core slot, I/O slot
// R12 - Reads take newest matching stage, else array

// ----------------------------------------
// Return FIFO
// ----------------------------------------
module swfsr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData,
  output logic [AW:0]           level
);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             nonEmpty_ff;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;

  assign inReady  = (cnt_ff < (AW+1)'(DEPTH));
  assign nxt_cnt  = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign outValid = nonEmpty_ff;
  assign outData  = store[rdPtr_ff];
  assign level    = cnt_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff   <= '0;
      nonEmpty_ff <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      nonEmpty_ff <= (nxt_cnt != '0);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      store[wrPtr_ff] <= inData;
    end
  end
endmodule // swfsr_fifo

// ----------------------------------------
// Top
// ----------------------------------------
module swfsr_top (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     coreWrite,
  input  wire logic                     coreRead,
  input  wire logic                     corePaired,
  input  wire logic                     coreExplicitSecondary,
  input  wire swfsr_pkg::swfsr_addr_type coreAddr,
  input  wire swfsr_pkg::swfsr_data_type coreWrData,
  output swfsr_pkg::swfsr_data_type      primaryElem_ff,
  output swfsr_pkg::swfsr_data_type      secondaryElem_ff,
  output logic                          coreRdValid_ff,
  input  wire logic                     ioWrite,
  input  wire logic                     ioRead,
  input  wire swfsr_pkg::swfsr_addr_type ioAddr,
  input  wire swfsr_pkg::swfsr_data_type ioWrData,
  output logic                          ioReady_ff,
  output logic                          ioRdValid,
  input  wire logic                     ioRdReady,
  output swfsr_pkg::swfsr_data_type      ioRdData
);
  import swfsr_pkg::*;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  wire              ioRdTake = ioRead && ioReady_ff;
  wire [IDX_W-1:0]  cIdx     = coreAddr[IDX_W-1:0];
  wire [IDX_W-1:0]  cCompIdx = cIdx + COMPANION_STEP; // R1
  wire [IDX_W-1:0]  iIdx     = ioAddr[IDX_W-1:0];
  wire              cBlk     = coreAddr[BLK_BIT];
  wire              iBlk     = ioAddr[BLK_BIT];
  logic [DATA_W-1:0] expData  [NBLK];
  logic [DATA_W-1:0] compData [NBLK];
  logic [DATA_W-1:0] ioData   [NBLK];
  logic              fifoInValid_ff;
  logic [DATA_W-1:0] fifoInData_ff;
  logic [FIFO_AW:0]  fifoLevel;

  // ----------------------------------------
  // One buffer and array per block
  // ----------------------------------------
  for (genvar b = 0; b < NBLK; b++) begin : g_blk
    logic [DATA_W-1:0] mem [2**IDX_W];
    logic              s1v_ff, s2v_ff;
    logic [IDX_W-1:0]  s1a_ff, s2a_ff;
    logic [DATA_W-1:0] s1d_ff, s2d_ff;

    function automatic logic [DATA_W-1:0] lookup(input logic [IDX_W-1:0] a);
      if (s1v_ff && s1a_ff == a) begin
        return s1d_ff;
      end else if (s2v_ff && s2a_ff == a) begin
        return s2d_ff;
      end
      return mem[a];
    endfunction

    wire cw      = coreWrite && (cBlk == 1'(b)); // R5 R10
    wire iw      = ioWrite && (iBlk == 1'(b)); // R5 R10
    wire anyRead = (coreRead && (cBlk == 1'(b))) || (ioRdTake && (iBlk == 1'(b)));
    wire single  = cw ^ iw;
    wire twoWr   = cw && iw;
    wire shift   = (single || (!cw && !iw && !anyRead)) && s1v_ff; // R9
    wire [IDX_W-1:0]  wa = cw ? cIdx : iIdx;
    wire [DATA_W-1:0] wd = cw ? coreWrData : ioWrData;

    assign expData[b]  = lookup(cIdx); // R12
    assign compData[b] = lookup(cCompIdx); // R3 R12
    assign ioData[b]   = lookup(iIdx); // R12

    always_ff @(posedge mclk) begin
      if (rst) begin
        s1v_ff <= 1'b0;
        s2v_ff <= 1'b0;
      end else if (twoWr) begin
        s2v_ff <= 1'b1;
        s1v_ff <= 1'b1;
      end else if (single) begin
        s1v_ff <= 1'b1; // R8
        s2v_ff <= s2v_ff || s1v_ff;
      end else if (shift) begin
        s1v_ff <= 1'b0;
        s2v_ff <= 1'b1;
      end
    end

    always_ff @(posedge mclk) begin
      if (twoWr) begin
        s2a_ff <= cIdx;
        s2d_ff <= coreWrData;
        s1a_ff <= iIdx;
        s1d_ff <= ioWrData;
      end else if (single) begin
        s1a_ff <= wa; // R8
        s1d_ff <= wd;
        if (s1v_ff) begin
          s2a_ff <= s1a_ff;
          s2d_ff <= s1d_ff;
        end
      end else if (shift) begin
        s2a_ff <= s1a_ff;
        s2d_ff <= s1d_ff;
      end
    end

    // Core slot retires stage two, I/O slot retires stage one
    always_ff @(posedge mclk) begin
      if (!rst && s2v_ff && (twoWr || shift)) begin
        mem[s2a_ff] <= s2d_ff; // R8 R11
      end
      if (!rst && s1v_ff && twoWr) begin
        mem[s1a_ff] <= s1d_ff; // R11
      end
    end
  end

  // ----------------------------------------
  // Core read return
  // ----------------------------------------
  wire [DATA_W-1:0] eWord = expData[cBlk];
  wire [DATA_W-1:0] pWord = corePaired ? compData[cBlk] : DATA_RESET;

  always_ff @(posedge mclk) begin
    if (rst) begin
      coreRdValid_ff   <= 1'b0;
      primaryElem_ff   <= DATA_RESET;
      secondaryElem_ff <= DATA_RESET;
    end else begin
      coreRdValid_ff <= coreRead; // R4
      if (coreRead) begin
        primaryElem_ff   <= coreExplicitSecondary ? pWord : eWord; // R2
        secondaryElem_ff <= coreExplicitSecondary ? eWord : pWord; // R2
      end
    end
  end

  // ----------------------------------------
  // I/O read return through FIFO
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      fifoInValid_ff <= 1'b0;
      fifoInData_ff  <= DATA_RESET;
      ioReady_ff     <= 1'b0;
    end else begin
      fifoInValid_ff <= ioRdTake; // R6 R7
      fifoInData_ff  <= ioData[iBlk];
      ioReady_ff  <= fifoLevel < IO_ROOM_LIMIT;
    end
  end

  swfsr_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (fifoInValid_ff),
    .inReady  (),
    .inData   (fifoInData_ff),
    .outValid (ioRdValid),
    .outReady (ioRdReady),
    .outData  (ioRdData),
    .level    (fifoLevel)
  );
endmodule // swfsr_top
